/* pkg/pt_pkg.sv */
// Package with register map, control layout and helpers for the paired timer.
package pt_pkg;

   // Byte offsets of the word registers on the bus.
   localparam logic [7:0] PT_OFS_CTRL_A = 8'h00;
   localparam logic [7:0] PT_OFS_CTRL_B = 8'h04;
   localparam logic [7:0] PT_OFS_CNT_A = 8'h08;
   localparam logic [7:0] PT_OFS_CNT_B = 8'h0C;
   localparam logic [7:0] PT_OFS_PER_A = 8'h10;
   localparam logic [7:0] PT_OFS_PER_B = 8'h14;
   localparam logic [7:0] PT_OFS_STS = 8'h18;
   localparam logic [7:0] PT_OFS_MSK = 8'h1C;

   // Writable bits of each control register; the rest read as zero.
   localparam logic [15:0] PT_CTRL_A_MASK = 16'hA37A;
   localparam logic [15:0] PT_CTRL_B_MASK = 16'hA372;
   localparam logic [15:0] PT_CTRL_RST = 16'h0000;
   localparam logic [15:0] PT_CNT_RST = 16'h0000;
   localparam logic [15:0] PT_PER_RST = 16'hFFFF;
   localparam logic [15:0] PT_CNT_LAST = 16'hFFFF;
   localparam logic [1:0] PT_IRQ_RST = 2'h0;

   // Status bit positions: period match or gate close of each timer.
   localparam int PT_STS_A = 0;
   localparam int PT_STS_B = 1;

   // Index of each pin source in the synchronised vector, equal to its source code.
   localparam int PT_NSRC = 4;
   localparam logic [1:0] PT_SRC_SECONDARY_OSCILLATOR = 2'h0;
   localparam logic [1:0] PT_SRC_OTHER = 2'h1;
   localparam logic [1:0] PT_SRC_LOW_POWER_RC_OSCILLATOR = 2'h2;
   localparam logic [1:0] PT_SRC_GEN = 2'h3;

   // Prescale codes.
   localparam logic [1:0] PT_PS_1 = 2'h0;
   localparam logic [1:0] PT_PS_8 = 2'h1;
   localparam logic [1:0] PT_PS_64 = 2'h2;

   // Control register layout, bit 15 first.
   typedef struct packed {
      logic run;
      logic rsv14;
      logic idle_stop;
      logic [2:0] rsv12;
      logic [1:0] ext_src;
      logic rsv7;
      logic gate_en;
      logic [1:0] prescale;
      logic pairing;
      logic rsv2;
      logic clk_src;
      logic rsv0;
   } pt_ctrl_t;

   // Last value of the prescale counter before it emits a tick.
   function automatic logic [7:0] pt_presc_last(input logic [1:0] sel);
      unique case (sel)
         PT_PS_1: pt_presc_last = 8'h00;
         PT_PS_8: pt_presc_last = 8'h07;
         PT_PS_64: pt_presc_last = 8'h3F;
         default: pt_presc_last = 8'hFF;
      endcase
   endfunction : pt_presc_last

endpackage : pt_pkg

/* hdl/pt_sync.sv */
// Three-stage synchroniser with filtered edge pulses for the pin sources.
`timescale 1ns/10ps
module pt_sync
   import pt_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [PT_NSRC-1:0] i_pin,
   output logic [PT_NSRC-1:0] o_level,
   output logic [PT_NSRC-1:0] o_rise,
   output logic [PT_NSRC-1:0] o_fall
);

   logic [PT_NSRC-1:0] s1_r; // First stage, read only by the second.
   logic [PT_NSRC-1:0] s2_r;
   logic [PT_NSRC-1:0] s3_r;
   logic [PT_NSRC-1:0] lvl_r; // Accepted level.
   logic [PT_NSRC-1:0] agree;

   // A change is taken only once the second and third stages agree.
   assign agree = ~(s2_r ^ s3_r);

   // Shift the pins through the stages and update the accepted level.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         lvl_r <= '0;
      end
      else
      begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= (agree & s3_r) | (~agree & lvl_r);
      end
   end

   // Edges are one-cycle pulses in the cycle before the level updates.
   assign o_rise = agree & s3_r & ~lvl_r;
   assign o_fall = agree & ~s3_r & lvl_r;
   assign o_level = lvl_r;

endmodule : pt_sync

/* hdl/pt_prescaler.sv */
// Prescale counter dividing one timer's input ticks by 1, 8, 64 or 256.
`timescale 1ns/10ps
module pt_prescaler
   import pt_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_clr,
   input wire logic i_tick,
   input wire logic [1:0] i_sel,
   output logic o_tick
);

   logic [7:0] cnt_r; // Input ticks seen since the last output tick.

   // Emit a tick on the input tick that completes the division.
   assign o_tick = i_tick & ~i_clr & (cnt_r == pt_presc_last(i_sel));

   // Count input ticks; a clear restarts the division from zero.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cnt_r <= 8'h00;
      else if (i_clr || o_tick)
         cnt_r <= 8'h00;
      else if (i_tick)
         cnt_r <= cnt_r + 8'h01;
   end

   property p_presc_clr;
      @(posedge i_clk) disable iff (!i_rst_b) i_clr |=> cnt_r == 8'h00;
   endproperty
   a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

   property p_presc_div;
      @(posedge i_clk) disable iff (!i_rst_b)
         o_tick |-> cnt_r == pt_presc_last(i_sel);
   endproperty
   a_presc_div: assert property (p_presc_div) else $error("prescaler tick at wrong count");

endmodule : pt_prescaler

/* hdl/pt_timer_pair.sv */
// Paired 16/32-bit timer with clock selection, gating, prescale and an AHB-Lite register slave.
`timescale 1ns/10ps

// Notes on behaviour
// - Primary run bit runs pair or primary.
// - Idle-stop bit halts timer in Idle.
// - Extended field picks one of four sources.
// - Clock source clear uses half system clock.
// - Primary source bit hands over to field.
// - Secondary alone counts its pin rising edges.
// - Gate enable only works on internal clock.
// - Prescale divides by 1, 8, 64, 256.
// - Control write while running clears prescaler.
// - Pairing bit 3 joins timers to 32.
// - Paired: secondary control bits have no effect.
// - Unused bits read zero; reset clears all but the periods, which load FFFF.
// - Primary holds low half, secondary high.
// - Paired: primary clock, secondary interrupt flag.
// - Converter trigger from pair or secondary.
module pt_timer_pair
   import pt_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_idle,
   input wire logic i_gen_ck,
   input wire logic i_other_ck,
   input wire logic i_secondary_oscillator,
   input wire logic i_low_power_rc_oscillator,
   output logic o_irq,
   output logic o_adc_trig
);

   pt_ctrl_t ctrl_a_r; // Primary control register.
   pt_ctrl_t ctrl_b_r; // Secondary control register.
   logic [15:0] cnt_a_r; // Primary count, low half when paired.
   logic [15:0] cnt_b_r; // Secondary count, high half when paired.
   logic [15:0] per_a_r;
   logic [15:0] per_b_r;
   logic [1:0] sts_r; // Sticky event flags.
   logic [1:0] msk_r; // Interrupt enables.
   logic half_r; // Toggles to give the half-rate internal tick.
   logic trig_r;
   logic [7:0] addr_r; // Latched write address for the data phase.
   logic wr_r; // A write data phase is in progress.
   logic [31:0] rdata_r;

   logic [PT_NSRC-1:0] pin_lvl;
   logic [PT_NSRC-1:0] pin_rise;
   logic [PT_NSRC-1:0] pin_fall;
   logic pair;
   logic run_a;
   logic run_b;
   logic src_a;
   logic src_b;
   logic tick_a;
   logic tick_b;
   logic match_a;
   logic match_b;
   logic match32;
   logic gclose_a;
   logic gclose_b;
   logic [1:0] ev;
   logic addr_ok;
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_cnt;
   logic [1:0] sts_clr;

   // Internal tick, optionally gated by the accepted gate level.
   function automatic logic int_tick(input pt_ctrl_t c, input logic half, input logic gate);
      int_tick = half & (~c.gate_en | gate);
   endfunction : int_tick

   // Gate close event: gating active on the internal clock and the gate falls.
   function automatic logic gate_close(input pt_ctrl_t c, input logic run, input logic fall);
      gate_close = run & ~c.clk_src & c.gate_en & fall;
   endfunction : gate_close

   // All four pin sources share one synchroniser so their delays match.
   pt_sync u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_pin({i_gen_ck, i_low_power_rc_oscillator, i_other_ck, i_secondary_oscillator}),
      .o_level(pin_lvl),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   assign pair = ctrl_a_r.pairing;

   assign run_a = ctrl_a_r.run & ~(i_idle & ctrl_a_r.idle_stop);
   assign run_b = pair ? run_a : ctrl_b_r.run & ~(i_idle & ctrl_b_r.idle_stop);

   assign src_a = ctrl_a_r.clk_src ? pin_rise[ctrl_a_r.ext_src]
                                   : int_tick(ctrl_a_r, half_r, pin_lvl[PT_SRC_GEN]);
   assign src_b = ctrl_b_r.clk_src ? pin_rise[PT_SRC_OTHER]
                                   : int_tick(ctrl_b_r, half_r, pin_lvl[PT_SRC_OTHER]);

   pt_prescaler u_presc_a (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_clr(~run_a | wr_ctrl_a),
      .i_tick(src_a),
      .i_sel(ctrl_a_r.prescale),
      .o_tick(tick_a)
   );

   // The secondary prescaler is held clear while paired so it restarts cleanly.
   pt_prescaler u_presc_b (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_clr(~run_b | wr_ctrl_b | pair),
      .i_tick(src_b),
      .i_sel(ctrl_b_r.prescale),
      .o_tick(tick_b)
   );

   // Period comparators for the halves and for the joined count.
   assign match_a = cnt_a_r == per_a_r;
   assign match_b = cnt_b_r == per_b_r;
   assign match32 = match_a & match_b;
   assign gclose_a = gate_close(ctrl_a_r, run_a, pin_fall[PT_SRC_GEN]);
   assign gclose_b = ~pair & gate_close(ctrl_b_r, run_b, pin_fall[PT_SRC_OTHER]);

   assign ev[PT_STS_A] = ~pair & ((tick_a & match_a) | gclose_a);
   assign ev[PT_STS_B] = pair ? (tick_a & match32) | gclose_a : (tick_b & match_b) | gclose_b;

   // Bus decode: writes land in the data phase, one cycle after the address.
   assign addr_ok = i_hsel & i_htrans[1] & i_hready;
   assign wr_ctrl_a = wr_r & (addr_r == PT_OFS_CTRL_A);
   assign wr_ctrl_b = wr_r & (addr_r == PT_OFS_CTRL_B);
   assign wr_cnt = wr_r & ((addr_r == PT_OFS_CNT_A) | (addr_r == PT_OFS_CNT_B));
   assign sts_clr = (wr_r && addr_r == PT_OFS_STS) ? i_hwdata[1:0] : 2'h0;

   // Latch the address phase of each write.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         wr_r <= 1'b0;
         addr_r <= 8'h00;
      end
      else
      begin
         wr_r <= addr_ok & i_hwrite;
         addr_r <= i_haddr[7:0];
      end
   end

   // Read data is captured at the address phase; a read just behind a write
   // to the same register therefore returns the older value.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         rdata_r <= 32'h0000_0000;
      else if (addr_ok && !i_hwrite)
      begin
         unique case (i_haddr[7:0])
            PT_OFS_CTRL_A: rdata_r <= {16'h0000, ctrl_a_r};
            PT_OFS_CTRL_B: rdata_r <= {16'h0000, ctrl_b_r};
            PT_OFS_CNT_A: rdata_r <= {16'h0000, cnt_a_r};
            PT_OFS_CNT_B: rdata_r <= {16'h0000, cnt_b_r};
            PT_OFS_PER_A: rdata_r <= {16'h0000, per_a_r};
            PT_OFS_PER_B: rdata_r <= {16'h0000, per_b_r};
            PT_OFS_STS: rdata_r <= {30'h0000_0000, sts_r};
            PT_OFS_MSK: rdata_r <= {30'h0000_0000, msk_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // The slave never stalls and never errors.
   assign o_hrdata = rdata_r;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctrl_a_r <= PT_CTRL_RST;
         ctrl_b_r <= PT_CTRL_RST;
      end
      else
      begin
         if (wr_ctrl_a)
            ctrl_a_r <= i_hwdata[15:0] & PT_CTRL_A_MASK;
         if (wr_ctrl_b)
            ctrl_b_r <= i_hwdata[15:0] & PT_CTRL_B_MASK;
      end
   end

   // Period registers and the interrupt mask.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         per_a_r <= PT_PER_RST;
         per_b_r <= PT_PER_RST;
         msk_r <= PT_IRQ_RST;
      end
      else if (wr_r)
      begin
         if (addr_r == PT_OFS_PER_A)
            per_a_r <= i_hwdata[15:0];
         if (addr_r == PT_OFS_PER_B)
            per_b_r <= i_hwdata[15:0];
         if (addr_r == PT_OFS_MSK)
            msk_r <= i_hwdata[1:0];
      end
   end

   // Free-running divide-by-two of the system clock.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         half_r <= 1'b0;
      else
         half_r <= ~half_r;
   end

   // Counters. A software write wins over a tick in the same cycle.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cnt_a_r <= PT_CNT_RST;
         cnt_b_r <= PT_CNT_RST;
      end
      else if (wr_cnt)
      begin
         if (addr_r == PT_OFS_CNT_A)
            cnt_a_r <= i_hwdata[15:0];
         else
            cnt_b_r <= i_hwdata[15:0];
      end
      else if (pair)
      begin
         if (tick_a)
            {cnt_b_r, cnt_a_r} <= match32 ? {PT_CNT_RST, PT_CNT_RST} : {cnt_b_r, cnt_a_r} + 32'h0000_0001;
      end
      else
      begin
         if (tick_a)
            cnt_a_r <= match_a ? PT_CNT_RST : cnt_a_r + 16'h0001;
         if (tick_b)
            cnt_b_r <= match_b ? PT_CNT_RST : cnt_b_r + 16'h0001;
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         sts_r <= PT_IRQ_RST;
      else
         sts_r <= (sts_r & ~sts_clr) | ev;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         trig_r <= 1'b0;
      else
         trig_r <= pair ? tick_a & match32 : tick_b & match_b;
   end

   assign o_adc_trig = trig_r;
   assign o_irq = |(sts_r & msk_r);

   property p_rsv_zero;
      @(posedge i_clk) disable iff (!i_rst_b)
         ((ctrl_a_r & ~PT_CTRL_A_MASK) == 16'h0000) && ((ctrl_b_r & ~PT_CTRL_B_MASK) == 16'h0000);
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved control bit set");

   property p_pair_stop;
      @(posedge i_clk) disable iff (!i_rst_b)
         pair && !ctrl_a_r.run && !wr_cnt |=> $stable({cnt_b_r, cnt_a_r});
   endproperty
   a_pair_stop: assert property (p_pair_stop) else $error("stopped pair counted");

   property p_idle_stop;
      @(posedge i_clk) disable iff (!i_rst_b)
         i_idle && ctrl_a_r.idle_stop && !wr_cnt |=> $stable(cnt_a_r);
   endproperty
   a_idle_stop: assert property (p_idle_stop) else $error("timer ran in idle");

   // Internal clock alternates
   // The control word must stay put over the window, since a write may switch to a pin source.
   property p_int_src;
      @(posedge i_clk) disable iff (!i_rst_b)
         (!ctrl_a_r.clk_src && !ctrl_a_r.gate_en && src_a && !wr_ctrl_a) ##1 !wr_ctrl_a
         |-> !src_a ##1 src_a;
   endproperty
   a_int_src: assert property (p_int_src) else $error("internal tick not half rate");

   property p_ext_src;
      @(posedge i_clk) disable iff (!i_rst_b)
         ctrl_a_r.clk_src |-> src_a == pin_rise[ctrl_a_r.ext_src];
   endproperty
   a_ext_src: assert property (p_ext_src) else $error("wrong extended source");

   property p_b_src;
      @(posedge i_clk) disable iff (!i_rst_b)
         ctrl_b_r.clk_src |-> src_b == pin_rise[PT_SRC_OTHER];
   endproperty
   a_b_src: assert property (p_b_src) else $error("secondary source wrong");

   property p_gate;
      @(posedge i_clk) disable iff (!i_rst_b)
         !ctrl_a_r.clk_src && ctrl_a_r.gate_en && !pin_lvl[PT_SRC_GEN] |-> !src_a;
   endproperty
   a_gate: assert property (p_gate) else $error("gated timer counted");

   property p_pair_b;
      @(posedge i_clk) disable iff (!i_rst_b) pair |-> !tick_b;
   endproperty
   a_pair_b: assert property (p_pair_b) else $error("secondary ticked while paired");

   property p_carry;
      @(posedge i_clk) disable iff (!i_rst_b)
         pair && tick_a && !match32 && cnt_a_r == PT_CNT_LAST && !wr_cnt
         |=> cnt_b_r == $past(cnt_b_r) + 16'h0001 && cnt_a_r == PT_CNT_RST;
   endproperty
   a_carry: assert property (p_carry) else $error("no carry into high half");

   property p_pair_flag;
      @(posedge i_clk) disable iff (!i_rst_b)
         pair && tick_a && match32 && !wr_cnt |=> sts_r[PT_STS_B] && o_adc_trig ##1 !o_adc_trig;
   endproperty
   a_pair_flag: assert property (p_pair_flag) else $error("pair match not flagged");

   property p_wrap;
      @(posedge i_clk) disable iff (!i_rst_b)
         !pair && tick_b && match_b && !wr_cnt |=> cnt_b_r == PT_CNT_RST && sts_r[PT_STS_B];
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at period");

   c_pair_match: cover property (@(posedge i_clk) disable iff (!i_rst_b) pair && tick_a && match32);
   c_gate_close: cover property (@(posedge i_clk) disable iff (!i_rst_b) gclose_a);
   c_b_trig: cover property (@(posedge i_clk) disable iff (!i_rst_b) !pair && o_adc_trig);

endmodule : pt_timer_pair

/* bench/pt_pin_model.sv */
// Stand-in for the four external clock and gate pins that feed the paired timer.
`timescale 1ns/10ps
module pt_pin_model
(
   input wire logic i_clk,
   input wire logic [3:0] i_en,
   output logic [3:0] o_pin
);
   // Toggle divider; three cycles per level keeps each level above the two-clock minimum.
   logic [1:0] div_r = 2'h0;

   // Stopped pins start low so no false edge appears at time zero.
   initial o_pin = 4'h0;

   // Enabled pins toggle together; a stopped oscillator rests low.
   always @(posedge i_clk)
   begin
      div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      if (div_r == 2'h2)
         o_pin <= ~o_pin & i_en;
      else
         o_pin <= o_pin & i_en;
   end
endmodule : pt_pin_model

/* bench/pt_timer_pair_tb_top.sv */
// Self-checking bench for the paired timer: register table, clocking, pairing and idle.
`timescale 1ns/10ps
module pt_timer_pair_tb_top
   import pt_pkg::*;
;
   // One table row: optional write, then a read that must return the expected word.
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} pt_row_t;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic idle = 1'b0;
   logic [3:0] pin_en = 4'h0;
   logic [3:0] pins;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic irq;
   logic trig;
   logic [31:0] rd;
   int errors = 0;
   int tests_run = 0;
   int trigs = 0;
   int n;
   int dv [4] = '{1, 8, 64, 256};
   pt_row_t rows [14] = '{
      '{1'b0, PT_OFS_CTRL_A, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, PT_OFS_CTRL_B, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, PT_OFS_CNT_A, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, PT_OFS_PER_B, 32'h0000_0000, 32'h0000_FFFF},
      '{1'b0, PT_OFS_STS, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, PT_OFS_MSK, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, PT_OFS_CTRL_A, 32'hFFFF_FFFF, 32'h0000_A37A},
      '{1'b1, PT_OFS_CTRL_A, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, PT_OFS_CTRL_B, 32'hFFFF_FFFF, 32'h0000_A372},
      '{1'b1, PT_OFS_CTRL_B, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, PT_OFS_PER_A, 32'h1234_5678, 32'h0000_5678},
      '{1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0000_0000},
      '{1'b1, PT_OFS_MSK, 32'hFFFF_FFFF, 32'h0000_0003},
      '{1'b1, PT_OFS_STS, 32'h0000_0003, 32'h0000_0000}};

   // Free-running system clock at 25 MHz.
   always #20 i_clk = ~i_clk;

   // Converter trigger pulses are counted, since each stands for one cycle only.
   always @(posedge i_clk)
      if (trig === 1'b1)
         trigs++;

   pt_timer_pair u_pt_timer_pair (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_idle(idle), .i_gen_ck(pins[3]),
      .i_other_ck(pins[1]), .i_secondary_oscillator(pins[0]), .i_low_power_rc_oscillator(pins[2]), .o_irq(irq), .o_adc_trig(trig));

   pt_pin_model u_pt_pin_model (.i_clk(i_clk), .i_en(pin_en), .o_pin(pins));

   // Single place that prints the verdict and ends the run.
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   // Compare seen against expected; four-state so an unknown never matches.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Advance to the next edge where the slave shows ready; a stuck bus ends the run.
   task automatic step_rdy();
      int k;
      k = 0;
      @(posedge i_clk);
      while (hready !== 1'b1)
      begin
         k++;
         if (k > 20)
         begin
            errors++;
            give_verdict();
         end
         @(posedge i_clk);
      end
   endtask : step_rdy

   // One single-word transfer: address phase, then data phase; read data taken at its end.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      step_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      step_rdy();
      rd = hrdata;
   endtask : bus

   // Wait for the interrupt under a bound; n ends as the number of cycles waited.
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
         @(posedge i_clk);
         n++;
      end
      // A wait that runs out of its bound counts as a mismatch.
      if (irq !== 1'b1)
         errors++;
   endtask : wait_irq

   // Stop both timers and clear both flags, so each test starts from a quiet state.
   task automatic clr(input string s);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_0000);
      bus(1'b1, PT_OFS_CTRL_B, 32'h0000_0000);
      bus(1'b1, PT_OFS_STS, 32'h0000_0003);
      @(posedge i_clk);
      check(irq, 32'h0000_0000);
      $display("test %s done", s);
   endtask : clr

   // Main sequence: reset, register table, then the hand-written cases.
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      check({hresp, irq, trig}, 32'h0000_0000);
      for (int i = 0; i < 14; i++)
      begin
         if (rows[i].wr)
            bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 32'h0000_0000);
         check(rd, rows[i].e);
      end
      $display("test register table done");
      // Internal half-rate clock through each prescale code; flag on every prescaled tick.
      bus(1'b1, PT_OFS_PER_A, 32'h0000_0000);
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b1, PT_OFS_CTRL_A, 32'h0000_8000 | (c << 4));
         wait_irq(600);
         check(n >= 2 * dv[c] - 2 && n <= 2 * dv[c] + 4, 32'h0000_0001);
         clr("prescale");
      end
      // A masked flag keeps the interrupt low until the mask opens.
      bus(1'b1, PT_OFS_MSK, 32'h0000_0000);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_8000);
      repeat (10) @(posedge i_clk);
      check(irq, 32'h0000_0000);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_0000);
      bus(1'b0, PT_OFS_STS, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      bus(1'b1, PT_OFS_MSK, 32'h0000_0003);
      @(posedge i_clk);
      check(irq, 32'h0000_0001);
      clr("mask");
      // Each extended source code must follow its own pin and no other.
      for (int c = 0; c < 4; c++)
      begin
         pin_en <= ~(4'h1 << c);
         bus(1'b1, PT_OFS_CTRL_A, 32'h0000_8002 | (c << 8));
         repeat (40) @(posedge i_clk);
         check(irq, 32'h0000_0000);
         pin_en <= 4'h1 << c;
         wait_irq(40);
         check(irq, 32'h0000_0001);
         pin_en <= 4'h0;
         clr("source");
      end
      check(trigs, 32'h0000_0000);
      // Secondary alone counts only its own pin, whatever its extended field holds.
      bus(1'b1, PT_OFS_PER_B, 32'h0000_0000);
      pin_en <= 4'h8;
      bus(1'b1, PT_OFS_CTRL_B, 32'h0000_8302);
      repeat (40) @(posedge i_clk);
      check(irq, 32'h0000_0000);
      pin_en <= 4'h2;
      wait_irq(40);
      bus(1'b1, PT_OFS_CTRL_B, 32'h0000_0000);
      bus(1'b0, PT_OFS_STS, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      pin_en <= 4'h0;
      check(trigs > 0, 32'h0000_0001);
      clr("secondary");
      // Paired: the flag needs the carry into the high half; secondary settings are ignored.
      trigs = 0;
      bus(1'b1, PT_OFS_CNT_A, 32'h0000_FFFF);
      bus(1'b1, PT_OFS_CNT_B, 32'h0000_0000);
      bus(1'b1, PT_OFS_PER_B, 32'h0000_0001);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_0008);
      bus(1'b1, PT_OFS_CTRL_B, 32'h0000_8030);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_8008);
      wait_irq(20);
      check(irq, 32'h0000_0001);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_0000);
      bus(1'b0, PT_OFS_STS, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      check(trigs > 0, 32'h0000_0001);
      clr("pairing");
      // Gated accumulation counts only while the generic pin holds the gate open.
      bus(1'b1, PT_OFS_PER_A, 32'h0000_0000);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_8040);
      repeat (20) @(posedge i_clk);
      check(irq, 32'h0000_0000);
      pin_en <= 4'h8;
      wait_irq(40);
      check(irq, 32'h0000_0001);
      pin_en <= 4'h0;
      clr("gate");
      // Idle halts a timer only when its idle-stop bit is set.
      idle <= 1'b1;
      bus(1'b1, PT_OFS_PER_A, 32'h0000_FFFF);
      bus(1'b1, PT_OFS_CNT_A, 32'h0000_0000);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_A000);
      repeat (20) @(posedge i_clk);
      bus(1'b0, PT_OFS_CNT_A, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b1, PT_OFS_CTRL_A, 32'h0000_8000);
      repeat (20) @(posedge i_clk);
      bus(1'b0, PT_OFS_CNT_A, 32'h0000_0000);
      check(rd != 32'h0000_0000, 32'h0000_0001);
      idle <= 1'b0;
      clr("idle");
      give_verdict();
   end
endmodule : pt_timer_pair_tb_top
